//--- core/cmb_pkg.sv
package cmb_pkg;
	// ========================================
	// buffer geometry
	localparam int CMB_NUM_BUFFERS   = 32;
	localparam int CMB_WORDS_PER_BUF = 8;
	localparam int CMB_WORD_W        = 16;
	localparam int CMB_BYTE_W        = 8;
	localparam int CMB_PAYLOAD_BYTES = 8;
	localparam int CMB_FILTER_W      = 5;
	// ========================================
	// word index inside one buffer
	localparam logic [2:0] CMB_W_STD_ID  = 3'h0;
	localparam logic [2:0] CMB_W_EXT_ID  = 3'h1;
	localparam logic [2:0] CMB_W_LENGTH  = 3'h2;
	localparam logic [2:0] CMB_W_DATA01  = 3'h3;
	localparam logic [2:0] CMB_W_DATA67  = 3'h6;
	localparam logic [2:0] CMB_W_STATUS  = 3'h7;
	// ========================================
	// implemented-bit masks per word
	localparam logic [15:0] CMB_MASK_STD_ID = 16'h1FFF;
	localparam logic [15:0] CMB_MASK_EXT_ID = 16'h0FFF;
	localparam logic [15:0] CMB_MASK_LENGTH = 16'hFF1F;
	localparam logic [15:0] CMB_MASK_DATA   = 16'hFFFF;
	localparam logic [15:0] CMB_MASK_STATUS = 16'h1F00;
	// ========================================
	// field positions
	localparam int CMB_STD_ID_LSB = 2;
	localparam int CMB_IDE_BIT    = 0;
	localparam int CMB_SRR_BIT    = 1;
	localparam int CMB_EXT_HI_LSB = 0;
	localparam int CMB_EXT_LO_LSB = 10;
	localparam int CMB_RTR_BIT    = 9;
	localparam int CMB_RSV_HI_BIT = 8;
	localparam int CMB_RSV_LO_BIT = 4;
	localparam int CMB_DLC_LSB    = 0;
	localparam int CMB_FILTER_LSB = 8;
	localparam int CMB_EXT_LO_W   = 6;
	localparam int CMB_EXT_HI_W   = 12;
	localparam int CMB_STD_ID_W   = 11;
	localparam int CMB_EXT_ID_W   = 18;
	localparam int CMB_FULL_ID_W  = 29;
	localparam int CMB_DLC_W      = 4;
endpackage

//--- core/cmb_message_ram.sv
`timescale 1ns/100ps
// Functional notes
// R1 - The extended-identifier word keeps identifier bits 17..6 in bits 11..0 and reads zero in bits 15..12.
// R2 - The length word keeps identifier bits 5..0 in bits 15..10.
// R3 - Length word bit 9 is the remote request flag, one for remote and zero for data; fetch uses it for extended frames only.
// R4 - Writers must keep reserved bits 8 and 4 of the length word at zero.
// R5 - Length word bits 3..0 hold the data length code and bits 7..5 read zero.
// R6 - Each buffer has eight eight-bit payload bytes numbered zero to seven.
// R7 - Payload bytes pack two per word with the higher-numbered byte in the upper half.
// R8 - There are thirty-two buffers, 0 to 31, all with the same layout.
// R9 - On a stored receive the accepting filter number goes to status bits 12..8, unused on transmit.
// R10 - Status bits 15..13 and 7..0 read zero.
// R11 - The first word holds the standard identifier in bits 12..2 and reads zero in bits 15..13.
// R12 - First word bit 0 selects extended format when one and standard when zero.
// R13 - Buffers live in a DMA-reachable RAM, not among the special function registers.
// R14 - The 29-bit extended identifier is the standard identifier above the eighteen extended bits.
module cmb_message_ram
	import cmb_pkg::*;
#(
	parameter int NUM_BUFFERS = CMB_NUM_BUFFERS
)(
	input  wire logic                     core_clk,
	input  wire logic                     resetn,
	input  wire logic                     dma_req,
	input  wire logic                     dma_we,
	input  wire logic [1:0]               dma_byte_en,
	input  wire logic [4:0]               dma_buf,
	input  wire logic [2:0]               dma_word,
	input  wire logic [15:0]              dma_wdata,
	output logic      [15:0]              dma_rdata,
	output logic                          dma_rvalid,
	input  wire logic                     eng_rd_req,
	input  wire logic [4:0]               eng_rd_buf,
	output logic      [CMB_FULL_ID_W-1:0] eng_identifier,
	output logic                          eng_extended,
	output logic                          eng_remote,
	output logic      [CMB_DLC_W-1:0]     eng_length,
	output logic      [63:0]              eng_payload,
	output logic                          eng_rd_valid,
	input  wire logic                     eng_rx_store,
	input  wire logic [4:0]               eng_rx_buf,
	input  wire logic [CMB_FULL_ID_W-1:0] eng_rx_identifier,
	input  wire logic                     eng_rx_extended,
	input  wire logic                     eng_rx_remote,
	input  wire logic [CMB_DLC_W-1:0]     eng_rx_length,
	input  wire logic [63:0]              eng_rx_payload,
	input  wire logic [CMB_FILTER_W-1:0]  eng_rx_filter
);

	// ========================================
	// elaboration checks: the flat index is five buffer bits over three word bits, so the count is fixed
	generate
		if (NUM_BUFFERS != CMB_NUM_BUFFERS)
		begin : g_bad_count
			$error("cmb_message_ram: buffer count must be 32");
		end
		if (CMB_PAYLOAD_BYTES != 2 * (CMB_WORDS_PER_BUF - 4))
		begin : g_bad_layout
			$error("cmb_message_ram: payload words do not fill the buffer");
		end
	endgenerate

	// ========================================
	// storage: word array, no reset since contents are undefined at power-on
	logic [15:0] mem_q [NUM_BUFFERS*CMB_WORDS_PER_BUF]; // R8 R13

	// flat word index: buffer number above word number
	function automatic logic [7:0] word_at(input logic [4:0] b, input logic [2:0] w);
		word_at = {b, w};
	endfunction

	function automatic logic [15:0] word_mask(input logic [2:0] idx);
		case (idx)
			CMB_W_STD_ID: word_mask = CMB_MASK_STD_ID; // R11
			CMB_W_EXT_ID: word_mask = CMB_MASK_EXT_ID; // R1
			CMB_W_LENGTH: word_mask = CMB_MASK_LENGTH; // R5
			CMB_W_STATUS: word_mask = CMB_MASK_STATUS; // R10
			default:      word_mask = CMB_MASK_DATA;
		endcase
	endfunction

	// ========================================
	// dma side decode; byte lanes let software patch one payload byte without a read-modify-write
	wire  [7:0]  dma_idx     = word_at(dma_buf, dma_word);
	wire  [15:0] lane_mask   = {{8{dma_byte_en[1]}}, {8{dma_byte_en[0]}}};
	wire  [15:0] dma_wmask   = lane_mask & word_mask(dma_word);
	wire         dma_wr      = dma_req & dma_we;
	wire         dma_rd_take = dma_req & ~dma_we;
	wire  [15:0] dma_merge   = (mem_q[dma_idx] & ~dma_wmask) | (dma_wdata & dma_wmask);
	wire  [15:0] dma_rd_d    = mem_q[dma_idx] & word_mask(dma_word);
	// a dma write loses against a frame landing in the same buffer in the same cycle
	wire         dma_wr_keep = dma_wr & ~(eng_rx_store & (eng_rx_buf == dma_buf));

	// ========================================
	// engine receive store image
	wire  [CMB_STD_ID_W-1:0] rx_std_id = eng_rx_extended ? eng_rx_identifier[CMB_FULL_ID_W-1:CMB_EXT_ID_W]
	                                                     : eng_rx_identifier[CMB_STD_ID_W-1:0];
	wire  [CMB_EXT_ID_W-1:0] rx_ext_id = eng_rx_identifier[CMB_EXT_ID_W-1:0];
	wire  [15:0] rx_w_std  = {3'h0, rx_std_id, 1'b0, eng_rx_extended}; // R11 R12 R14
	wire  [15:0] rx_w_ext  = {4'h0, rx_ext_id[CMB_EXT_ID_W-1:CMB_EXT_LO_W]}; // R1
	// reserved bits stored as zero on receive; the remote flag goes to the length word only
	wire  [15:0] rx_w_len  = {rx_ext_id[CMB_EXT_LO_W-1:0], eng_rx_remote, 1'b0, 3'h0, 1'b0, eng_rx_length}; // R2 R3 R5
	wire  [15:0] rx_w_stat = {3'h0, eng_rx_filter, 8'h00}; // R9 R10

	// ========================================
	// engine transmit fetch decode
	wire  [15:0] tx_std_w  = mem_q[word_at(eng_rd_buf, CMB_W_STD_ID)];
	wire  [15:0] tx_ext_w  = mem_q[word_at(eng_rd_buf, CMB_W_EXT_ID)];
	wire  [15:0] tx_len_w  = mem_q[word_at(eng_rd_buf, CMB_W_LENGTH)];
	wire         tx_ext    = tx_std_w[CMB_IDE_BIT]; // R12
	wire  [CMB_STD_ID_W-1:0] tx_std_id = tx_std_w[CMB_STD_ID_LSB +: CMB_STD_ID_W]; // R11
	wire  [CMB_EXT_ID_W-1:0] tx_ext_id = {tx_ext_w[CMB_EXT_HI_LSB +: CMB_EXT_HI_W],
	                                      tx_len_w[CMB_EXT_LO_LSB +: CMB_EXT_LO_W]}; // R1 R2
	wire  [CMB_FULL_ID_W-1:0] tx_id = tx_ext ? {tx_std_id, tx_ext_id} // R14
	                                         : {{CMB_EXT_ID_W{1'b0}}, tx_std_id};
	// reserved bits 8 and 4 are ignored on fetch; software keeps them zero
	// limitation: a standard frame takes its remote flag from the substitute bit of the first word
	wire         tx_rtr    = tx_ext ? tx_len_w[CMB_RTR_BIT] : tx_std_w[CMB_SRR_BIT]; // R3 R4
	wire  [63:0] tx_pay;

	genvar g;
	generate
		for (g = 0; g < CMB_PAYLOAD_BYTES/2; g++)
		begin : g_pay
			// upper byte of each word is the next payload byte
			assign tx_pay[g*CMB_WORD_W +: CMB_WORD_W] = mem_q[word_at(eng_rd_buf, CMB_W_DATA01 + 3'(g))]; // R6 R7
		end
	endgenerate

	// ========================================
	// storage writes: engine receive has priority over a same-cycle dma write
	always_ff @(posedge core_clk)
	begin
		if (eng_rx_store)
		begin
			mem_q[word_at(eng_rx_buf, CMB_W_STD_ID)] <= rx_w_std;
			mem_q[word_at(eng_rx_buf, CMB_W_EXT_ID)] <= rx_w_ext;
			mem_q[word_at(eng_rx_buf, CMB_W_LENGTH)] <= rx_w_len;
			for (int i = 0; i < CMB_PAYLOAD_BYTES/2; i++)
				mem_q[word_at(eng_rx_buf, CMB_W_DATA01 + 3'(i))] <= eng_rx_payload[i*CMB_WORD_W +: CMB_WORD_W]; // R7
			mem_q[word_at(eng_rx_buf, CMB_W_STATUS)] <= rx_w_stat; // R9
		end
		if (dma_wr_keep)
			mem_q[dma_idx] <= dma_merge;
	end

	// ========================================
	// registered answers; every output comes straight from a flop
	always_ff @(posedge core_clk)
	begin
		if (!resetn)
			dma_rvalid <= 1'b0;
		else
			dma_rvalid <= dma_rd_take;
	end

	always_ff @(posedge core_clk)
	begin
		if (!resetn)
			dma_rdata <= 16'h0000;
		else if (dma_rd_take)
			dma_rdata <= dma_rd_d; // R1 R5 R10 R11
	end

	always_ff @(posedge core_clk)
	begin
		if (!resetn)
			eng_rd_valid <= 1'b0;
		else
			eng_rd_valid <= eng_rd_req;
	end

	// fetched frame holds until the next fetch so the engine may shift it out at its own pace
	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			eng_identifier <= '0;
			eng_extended   <= 1'b0;
			eng_remote     <= 1'b0;
			eng_length     <= '0;
			eng_payload    <= 64'h0;
		end
		else if (eng_rd_req)
		begin
			eng_identifier <= tx_id;
			eng_extended   <= tx_ext;
			eng_remote     <= tx_rtr;
			eng_length     <= tx_len_w[CMB_DLC_LSB +: CMB_DLC_W]; // R5
			eng_payload    <= tx_pay;
		end
	end

	// ========================================
	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	// helper views of storage for the checks
	wire  [15:0] chk_first_pair = mem_q[word_at(eng_rd_buf, CMB_W_DATA01)];
	wire  [7:0]  chk_dma_upper  = mem_q[dma_idx][15:8];

	// ========================================
	// dma read masks, timing and lane writes
	stat_read_mask_a: assert property (dma_rvalid && $past(dma_word) == CMB_W_STATUS // R10
		|-> (dma_rdata & 16'hE0FF) == 16'h0000)
		else $error("status read shows unimplemented bits");

	len_read_mask_a: assert property (dma_rvalid && $past(dma_word) == CMB_W_LENGTH // R5
		|-> dma_rdata[7:5] == 3'h0)
		else $error("length read shows bits 7..5");

	eid_read_mask_a: assert property (dma_rvalid && $past(dma_word) == CMB_W_EXT_ID // R1
		|-> dma_rdata[15:12] == 4'h0)
		else $error("ext id read shows bits 15..12");

	sid_read_mask_a: assert property (dma_rvalid && $past(dma_word) == CMB_W_STD_ID // R11
		|-> dma_rdata[15:13] == 3'h0)
		else $error("std id read shows bits 15..13");

	rd_valid_timing_a: assert property (dma_rd_take |=> dma_rvalid) // R13
		else $error("dma read answer late");

	rd_data_hold_a: assert property (!dma_rd_take |=> $stable(dma_rdata)) // R13
		else $error("dma read data moved without a read");

	lane_keep_a: assert property (dma_wr_keep && dma_byte_en == 2'h1 // R7
		|=> mem_q[$past(dma_idx)][15:8] == $past(chk_dma_upper))
		else $error("low lane write touched the upper byte");

	// ========================================
	// receive store
	filter_store_a: assert property (eng_rx_store && !dma_rd_take // R9
		##1 dma_rd_take && dma_buf == $past(eng_rx_buf) && dma_word == CMB_W_STATUS
		|=> dma_rdata[12:8] == $past(eng_rx_filter, 2))
		else $error("filter number not stored");

	store_status_a: assert property (eng_rx_store // R10
		|=> mem_q[word_at($past(eng_rx_buf), CMB_W_STATUS)] == {3'h0, $past(eng_rx_filter), 8'h00})
		else $error("status word not filter number alone");

	store_rsv_a: assert property (eng_rx_store // R4
		|=> mem_q[word_at($past(eng_rx_buf), CMB_W_LENGTH)][CMB_RSV_HI_BIT] == 1'b0
		&& mem_q[word_at($past(eng_rx_buf), CMB_W_LENGTH)][CMB_RSV_LO_BIT] == 1'b0)
		else $error("reserved length bits stored non-zero");

	store_format_a: assert property (eng_rx_store // R12
		|=> mem_q[word_at($past(eng_rx_buf), CMB_W_STD_ID)][CMB_IDE_BIT] == $past(eng_rx_extended))
		else $error("stored format bit wrong");

	// ========================================
	// engine fetch
	std_id_fetch_a: assert property (eng_rd_valid && !eng_extended // R14
		|-> eng_identifier[28:11] == 18'h0)
		else $error("standard id has upper bits");

	ext_flag_a: assert property (eng_rd_req |=> eng_extended == $past(tx_std_w[CMB_IDE_BIT])) // R12
		else $error("format flag not from bit 0");

	eng_valid_timing_a: assert property (eng_rd_valid == $past(eng_rd_req)) // R8
		else $error("fetch answer not one cycle after request");

	eng_hold_a: assert property (!eng_rd_req // R6
		|=> $stable(eng_identifier) && $stable(eng_payload) && $stable(eng_length))
		else $error("fetched frame moved without a fetch");

	ext_remote_a: assert property (eng_rd_req && tx_ext // R3
		|=> eng_remote == $past(tx_len_w[CMB_RTR_BIT]))
		else $error("extended remote flag not from length bit 9");

	std_remote_a: assert property (eng_rd_req && !tx_ext // R3
		|=> eng_remote == $past(tx_std_w[CMB_SRR_BIT]))
		else $error("standard remote flag not from first word bit 1");

	len_fetch_a: assert property (eng_rd_req // R5
		|=> eng_length == $past(tx_len_w[CMB_DLC_W-1:0]))
		else $error("length code not from bits 3..0");

	payload_order_a: assert property (eng_rd_req // R7
		|=> eng_payload[2*CMB_BYTE_W-1:CMB_BYTE_W] == $past(chk_first_pair[15:8]))
		else $error("byte 1 not from upper half of first data word");

	ext_id_fetch_a: assert property (eng_rd_req && tx_ext // R2
		|=> eng_identifier[CMB_EXT_ID_W-1:0]
		== {$past(tx_ext_w[CMB_EXT_HI_W-1:0]), $past(tx_len_w[CMB_WORD_W-1:CMB_EXT_LO_LSB])})
		else $error("extended id bits misplaced");

	// main scenarios
	rx_store_c: cover property (eng_rx_store);
	tx_ext_c:   cover property (eng_rd_valid && eng_extended && eng_remote);
	tx_std_c:   cover property (eng_rd_valid && !eng_extended);
	dma_rd_c:   cover property (dma_rvalid);
	lane_wr_c:  cover property (dma_wr_keep && dma_byte_en == 2'h1);
endmodule

//--- sim/cmb_engine_model.sv
`timescale 1ns/100ps
module cmb_engine_model
	import cmb_pkg::*;
(
	input  wire logic        core_clk,
	output logic             eng_rx_store,
	output logic [4:0]       eng_rx_buf,
	output logic [28:0]      eng_rx_identifier,
	output logic             eng_rx_extended,
	output logic             eng_rx_remote,
	output logic [3:0]       eng_rx_length,
	output logic [63:0]      eng_rx_payload,
	output logic [4:0]       eng_rx_filter
);
	initial {eng_rx_store, eng_rx_buf, eng_rx_identifier, eng_rx_payload, eng_rx_filter} = '0;
	initial {eng_rx_extended, eng_rx_remote, eng_rx_length} = '0;
	// extended data frame, length 5; identifier and payload go inverse once released
	task automatic store(input logic [4:0] b, input logic [28:0] id, input logic [63:0] pl, input logic [4:0] f);
		{eng_rx_buf, eng_rx_identifier, eng_rx_payload, eng_rx_filter} = {b, id, pl, f};
		{eng_rx_store, eng_rx_extended, eng_rx_remote, eng_rx_length} = {3'h6, 4'h5};
		@(negedge core_clk);
		{eng_rx_store, eng_rx_identifier, eng_rx_payload} = {1'b0, ~id, ~pl};
	endtask
endmodule

//--- sim/tb_cmb_message_ram.sv
`timescale 1ns/100ps
module tb_cmb_message_ram
	import cmb_pkg::*;
;
	logic        core_clk = 1'b0;
	logic        resetn = 1'b0;
	logic        dma_req = 1'b0, dma_we = 1'b0, eng_rd_req = 1'b0;
	logic [1:0]  dma_byte_en = 2'h3;
	logic [4:0]  dma_buf = 5'h00, eng_rd_buf = 5'h00, eng_rx_buf, eng_rx_filter;
	logic [2:0]  dma_word = 3'h0;
	logic [15:0] dma_wdata = 16'h0000, dma_rdata;
	logic        dma_rvalid, eng_extended, eng_remote, eng_rd_valid;
	logic        eng_rx_store, eng_rx_extended, eng_rx_remote;
	logic [28:0] eng_identifier, eng_rx_identifier;
	logic [3:0]  eng_length, eng_rx_length;
	logic [63:0] eng_payload, eng_rx_payload;
	int          n_errors = 0, total_checks = 0;
	always #10 core_clk = ~core_clk;
	cmb_message_ram u_dut (.core_clk, .resetn, .dma_req, .dma_we, .dma_byte_en, .dma_buf, .dma_word,
		.dma_wdata, .dma_rdata, .dma_rvalid, .eng_rd_req, .eng_rd_buf, .eng_identifier, .eng_extended,
		.eng_remote, .eng_length, .eng_payload, .eng_rd_valid, .eng_rx_store, .eng_rx_buf, .eng_rx_identifier,
		.eng_rx_extended, .eng_rx_remote, .eng_rx_length, .eng_rx_payload, .eng_rx_filter);
	cmb_engine_model u_eng (.core_clk, .eng_rx_store, .eng_rx_buf, .eng_rx_identifier, .eng_rx_extended,
		.eng_rx_remote, .eng_rx_length, .eng_rx_payload, .eng_rx_filter);
	task automatic wrap_up();
		if (n_errors == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// one access per call; wdata goes inverse afterwards; a write leaves an idle cycle
	task automatic dreq(input logic we, input logic [4:0] b, input logic [2:0] w, input logic [15:0] d,
		input logic [1:0] be);
		{dma_req, dma_we, dma_buf, dma_word, dma_wdata, dma_byte_en} = {1'b1, we, b, w, d, be};
		@(negedge core_clk);
		{dma_req, dma_wdata} = {1'b0, ~d};
		if (we)
			@(negedge core_clk);
	endtask
	task automatic wait_hi(ref logic s);
		for (int n = 0; s !== 1'b1; n++)
		begin
			if (n > 4)
			begin
				n_errors++;
				wrap_up();
			end
			@(negedge core_clk);
		end
	endtask
	task automatic drd(input logic [4:0] b, input logic [2:0] w, output logic [15:0] d);
		dreq(1'b0, b, w, 16'h0000, 2'h3);
		wait_hi(dma_rvalid);
		d = dma_rdata;
		@(negedge core_clk);
	endtask
	task automatic fetch(input logic [4:0] b);
		{eng_rd_req, eng_rd_buf} = {1'b1, b};
		@(negedge core_clk);
		eng_rd_req = 1'b0;
		wait_hi(eng_rd_valid);
	endtask
	task automatic s_masks();
		logic [15:0] d;
		logic [2:0]  w [4] = '{3'h0, 3'h1, 3'h2, 3'h7};
		logic [15:0] m [4] = '{16'h1FFF, 16'h0FFF, 16'hFF1F, 16'h1F00};
		for (int i = 0; i < 4; i++)
		begin
			dreq(1'b1, 5'h1F, w[i], 16'hFEEF, 2'h3);
			drd(5'h1F, w[i], d);
			chk("mask", d, 16'hFEEF & m[i]);
		end
	endtask
	task automatic s_ext();
		logic [17:0] e;
		logic [15:0] d;
		e = 18'h2ABCD;
		dreq(1'b1, 5'h07, 3'h0, {3'h0, 11'h5A5, 2'h1}, 2'h3);
		dreq(1'b1, 5'h07, 3'h1, {4'h0, e[17:6]}, 2'h3);
		dreq(1'b1, 5'h07, 3'h2, {e[5:0], 6'h20, 4'h8}, 2'h3);
		for (int k = 0; k < 4; k++)
			dreq(1'b1, 5'h07, 3'h3 + 3'(k), 16'hA1A0 + 16'(k) * 16'h0202, 2'h3);
		// a byte lane write must leave the other lane alone
		dreq(1'b1, 5'h07, 3'h6, 16'h5555, 2'h1);
		drd(5'h07, 3'h6, d);
		chk("lane", d, 16'hA755);
		dreq(1'b1, 5'h07, 3'h6, 16'hA6A6, 2'h1);
		fetch(5'h07);
		chk("id", eng_identifier, {11'h5A5, e});
		chk("ext rem len", {eng_extended, eng_remote, eng_length}, 6'h38);
		chk("payload", eng_payload, 64'hA7A6A5A4A3A2A1A0);
	endtask
	task automatic s_std();
		dreq(1'b1, 5'h08, 3'h0, {3'h0, 11'h3C3, 2'h2}, 2'h3);
		dreq(1'b1, 5'h08, 3'h2, 16'hFC03, 2'h3);
		for (int k = 0; k < 4; k++)
			dreq(1'b1, 5'h08, 3'h3 + 3'(k), 16'h0100 + 16'(k) * 16'h0202, 2'h3);
		fetch(5'h08);
		chk("std payload", eng_payload, 64'h0706050403020100);
		chk("std id", eng_identifier, {18'h0, 11'h3C3});
		chk("std ext rem len", {eng_extended, eng_remote, eng_length}, 6'h13);
	endtask
	task automatic s_rx();
		logic [15:0] d;
		logic [2:0]  w [5] = '{3'h7, 3'h0, 3'h1, 3'h2, 3'h6};
		logic [15:0] x [5] = '{16'h1300, 16'h048D, 16'h0F03, 16'hC405, 16'hF0E1};
		u_eng.store(5'h05, {11'h123, 18'h3C0F1}, 64'hF0E1D2C3B4A59687, 5'h13);
		for (int i = 0; i < 5; i++)
		begin
			drd(5'h05, w[i], d);
			chk("rx word", d, x[i]);
		end
	endtask
	initial
	begin
		repeat (12) @(negedge core_clk);
		resetn = 1'b1;
		@(negedge core_clk);
		chk("reset", {dma_rvalid, eng_rd_valid, dma_rdata}, 18'h0);
		s_masks();
		s_ext();
		s_std();
		s_rx();
		wrap_up();
	end
endmodule
